// File: src/ldbc_decoder.sv
/*
 * Two-byte configuration command decoder: partial first line, line-group inversion depth
 * and charge pump clock division, with the inversion release command.
 * Assumes command bytes arrive as one-cycle write strobes synchronous to CLK_SYS, and that the
 * oscillator arrives as a one-cycle tick per oscillator period on the same clock.
 */
`timescale 1ns/1ns
module ldbc_decoder (
    input wire logic CLK_SYS, // System clock, 50 MHz.
    input wire logic RESETN, // Asynchronous reset, active low.
    input wire logic CE, // Clock enable; all state holds while low.
    input wire logic CMD_WR, // One-cycle write strobe from the host port.
    input wire logic COMMAND_DATA_SELECT, // Low marks a command write, high display data.
    input wire logic [7:0] CMD_BYTE, // Byte written by the host.
    input wire logic MAX_DUTY_PIN_LOW, // Duty select pin, low bit.
    input wire logic MAX_DUTY_PIN_HIGH, // Duty select pin, high bit.
    input wire logic PARTIAL_MODE, // High while partial display mode is on.
    input wire logic [2:0] PARTIAL_DUTY, // Partial duty code, 0 is 1/9 and 1 is 1/17.
    input wire logic OSC_TICK, // One pulse per oscillator clock period.
    output logic [5:0] PARTIAL_FIRST_LINE, // First line the partial display uses.
    output logic LINE_INVERSION_ON, // High while line-group inversion drives the panel.
    output logic [5:0] INVERSION_LINES, // Scan lines per polarity inversion, 1 to 32.
    output logic [3:0] PUMP_DIV_CODE, // Current pump clock division code.
    output logic PUMP_TICK, // One pulse per pump clock period.
    output logic PAIR_PENDING // High while a prefix waits for its data byte.
);

    ////////////////////////////////////////////////////////////////////////////
    // State record.

    typedef struct packed {
        ldbc_pkg::ldbc_state_t state;
        logic [5:0] line;
        logic [4:0] inv_cnt;
        logic inv_on;
        logic [3:0] div;
        logic [4:0] osc_cnt;
        logic [5:0] line_eff;
        logic inv_act;
        logic [5:0] inv_lines;
        logic tick;
        logic busy;
    } ldbc_regs_t;

    localparam ldbc_regs_t REGS_RESET = '{
        state: ldbc_pkg::ST_IDLE,
        line: ldbc_pkg::LINE_RESET,
        inv_cnt: ldbc_pkg::INV_RESET,
        inv_on: 1'b0,
        div: ldbc_pkg::DIV_RESET,
        osc_cnt: 5'h00,
        line_eff: ldbc_pkg::LINE_RESET,
        inv_act: 1'b0,
        inv_lines: 6'h01,
        tick: 1'b0,
        busy: 1'b0
    };

    ldbc_regs_t r_reg;
    ldbc_regs_t r_next;
    logic cmd_take;
    logic [6:0] max_lines;
    logic [4:0] div_last;

    // Only command writes reach the decoder; display data leaves any pending pair waiting.
    // R15 command writes only
    assign cmd_take = CE && CMD_WR && !COMMAND_DATA_SELECT;

    // Maximum duty in scan lines, fixed by the two duty pins.
    always_comb begin
        unique case ({MAX_DUTY_PIN_HIGH, MAX_DUTY_PIN_LOW})
            2'b00: max_lines = ldbc_pkg::MAX_LINES_0;
            2'b01: max_lines = ldbc_pkg::MAX_LINES_1;
            2'b10: max_lines = ldbc_pkg::MAX_LINES_2;
            2'b11: max_lines = ldbc_pkg::MAX_LINES_3;
        endcase
    end

    // Last count of one pump period: 2n oscillator ticks, minus one.
    assign div_last = {r_reg.div, 1'b0} - 5'h01;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // The prefix alone changes only the state and busy fields, so the panel never sees half a pair.
    always_comb begin
        r_next = r_reg;
        r_next.tick = 1'b0;
        if (cmd_take) begin
            unique case (r_reg.state)
                ldbc_pkg::ST_IDLE: begin
                    // R1 line prefix
                    if (CMD_BYTE == ldbc_pkg::OP_LINE_PREFIX) begin
                        r_next.state = ldbc_pkg::ST_LINE;
                    end
                    // R5 inversion prefix
                    else if (CMD_BYTE == ldbc_pkg::OP_INV_PREFIX) begin
                        r_next.state = ldbc_pkg::ST_INV;
                    end
                    // R11 pump prefix
                    else if (CMD_BYTE == ldbc_pkg::OP_PUMP_PREFIX) begin
                        r_next.state = ldbc_pkg::ST_PUMP;
                    end
                    // R10 inversion release
                    else if (CMD_BYTE == ldbc_pkg::OP_INV_RELEASE) begin
                        r_next.inv_on = 1'b0;
                    end
                end
                // R2 store first line
                // R13 next command is the data
                ldbc_pkg::ST_LINE: begin
                    r_next.line = CMD_BYTE[5:0];
                    r_next.state = ldbc_pkg::ST_IDLE;
                end
                // R6 store line count
                // R8 inversion starts now
                ldbc_pkg::ST_INV: begin
                    r_next.inv_cnt = CMD_BYTE[4:0];
                    r_next.inv_on = 1'b1;
                    r_next.state = ldbc_pkg::ST_IDLE;
                end
                // R12 store division
                ldbc_pkg::ST_PUMP: begin
                    r_next.div = CMD_BYTE[3:0];
                    r_next.osc_cnt = 5'h00;
                    r_next.state = ldbc_pkg::ST_IDLE;
                end
            endcase
        end
        // R12 pump clock divider
        if (CE && OSC_TICK && !(cmd_take && r_reg.state == ldbc_pkg::ST_PUMP)) begin
            if (r_reg.div == 4'h0 || r_reg.osc_cnt >= div_last) begin
                r_next.osc_cnt = 5'h00;
                r_next.tick = 1'b1;
            end else begin
                r_next.osc_cnt = r_reg.osc_cnt + 5'h01;
            end
        end
        // R3 register drives display
        // R4 out of range gives zero
        if ({1'b0, r_next.line} > max_lines) begin
            r_next.line_eff = 6'h00;
        end else begin
            r_next.line_eff = r_next.line;
        end
        // R9 short duty cancels inversion
        r_next.inv_act = r_next.inv_on &&
            !(PARTIAL_MODE && (PARTIAL_DUTY == ldbc_pkg::DUTY_9 || PARTIAL_DUTY == ldbc_pkg::DUTY_17));
        // R7 count plus one
        r_next.inv_lines = {1'b0, r_next.inv_cnt} + 6'h01;
        r_next.busy = r_next.state != ldbc_pkg::ST_IDLE;
        if (!CE) begin
            r_next = r_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    // R14 reset division eight
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            r_reg <= REGS_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs come straight from the state record.
    assign PARTIAL_FIRST_LINE = r_reg.line_eff;
    assign LINE_INVERSION_ON = r_reg.inv_act;
    assign INVERSION_LINES = r_reg.inv_lines;
    assign PUMP_DIV_CODE = r_reg.div;
    assign PUMP_TICK = r_reg.tick;
    assign PAIR_PENDING = r_reg.busy;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    sequence s_cmd(logic [7:0] op);
        cmd_take && CMD_BYTE == op;
    endsequence

    sequence s_idle_cmd(logic [7:0] op);
        r_reg.state == ldbc_pkg::ST_IDLE ##0 s_cmd(op);
    endsequence

    property p_line_prefix;
        s_idle_cmd(ldbc_pkg::OP_LINE_PREFIX) |=> r_reg.state == ldbc_pkg::ST_LINE && PAIR_PENDING;
    endproperty
    a_line_prefix: assert property (p_line_prefix) else $error("Line prefix did not wait for data."); // R1

    property p_line_store;
        (r_reg.state == ldbc_pkg::ST_LINE && cmd_take) |=>
            r_reg.line == $past(CMD_BYTE[5:0]) && r_reg.state == ldbc_pkg::ST_IDLE;
    endproperty
    a_line_store: assert property (p_line_store) else $error("First line byte not stored."); // R2

    property p_line_hold;
        s_idle_cmd(ldbc_pkg::OP_LINE_PREFIX) |=> $stable(PARTIAL_FIRST_LINE);
    endproperty
    a_line_hold: assert property (p_line_hold) else $error("Prefix changed the first line."); // R3

    property p_line_zero;
        ({1'b0, r_reg.line} > max_lines && CE) |=> PARTIAL_FIRST_LINE == 6'h00 || $changed(r_reg.line);
    endproperty
    a_line_zero: assert property (p_line_zero) else $error("Out of range line not zero."); // R4

    property p_inv_load;
        (r_reg.state == ldbc_pkg::ST_INV && cmd_take) |=>
            INVERSION_LINES == {1'b0, $past(CMD_BYTE[4:0])} + 6'h01 && r_reg.inv_on;
    endproperty
    a_inv_load: assert property (p_inv_load) else $error("Inversion count not loaded."); // R7

    property p_inv_prefix;
        s_idle_cmd(ldbc_pkg::OP_INV_PREFIX) |=> r_reg.state == ldbc_pkg::ST_INV ##0 $stable(r_reg.inv_cnt);
    endproperty
    a_inv_prefix: assert property (p_inv_prefix) else $error("Inversion prefix misdecoded."); // R5

    property p_inv_release;
        s_idle_cmd(ldbc_pkg::OP_INV_RELEASE) |=> !LINE_INVERSION_ON;
    endproperty
    a_inv_release: assert property (p_inv_release) else $error("Release left inversion on."); // R10

    property p_inv_frame;
        (CE && PARTIAL_MODE && PARTIAL_DUTY <= ldbc_pkg::DUTY_17) |=> !LINE_INVERSION_ON;
    endproperty
    a_inv_frame: assert property (p_inv_frame) else $error("Short duty kept line inversion."); // R9

    property p_pump_load;
        (r_reg.state == ldbc_pkg::ST_PUMP && cmd_take) |=> PUMP_DIV_CODE == $past(CMD_BYTE[3:0]);
    endproperty
    a_pump_load: assert property (p_pump_load) else $error("Division code not loaded."); // R12

    property p_pump_pass;
        (CE && OSC_TICK && r_reg.div == 4'h0 && !cmd_take) |=> PUMP_TICK;
    endproperty
    a_pump_pass: assert property (p_pump_pass) else $error("Code zero did not pass the clock."); // R12

    // The count byte lands in the stored field, not only in the derived line total.
    property p_inv_count;
        (r_reg.state == ldbc_pkg::ST_INV && cmd_take) |=> r_reg.inv_cnt == $past(CMD_BYTE[4:0]);
    endproperty
    a_inv_count: assert property (p_inv_count) else $error("Inversion count field not stored."); // R6

    // The inversion prefix alone must not switch line-group inversion on or off.
    property p_inv_wait;
        s_idle_cmd(ldbc_pkg::OP_INV_PREFIX) |=> $stable(r_reg.inv_on);
    endproperty
    a_inv_wait: assert property (p_inv_wait) else $error("Inversion prefix changed the mode."); // R8

    // Once written, line inversion keeps acting until opcode 84h or a short partial duty overrides it.
    property p_inv_keep;
        (CE && !PARTIAL_MODE && r_reg.inv_on && !cmd_take) |=> LINE_INVERSION_ON;
    endproperty
    a_inv_keep: assert property (p_inv_keep) else $error("Line inversion dropped on its own."); // R8

    // The pump prefix waits for its byte and leaves the running division alone.
    property p_pump_prefix;
        s_idle_cmd(ldbc_pkg::OP_PUMP_PREFIX) |=> r_reg.state == ldbc_pkg::ST_PUMP && $stable(PUMP_DIV_CODE);
    endproperty
    a_pump_prefix: assert property (p_pump_prefix) else $error("Pump prefix misdecoded."); // R11

    // Loading a new code restarts the period, so no stray short pulse follows the load.
    property p_pump_restart;
        (r_reg.state == ldbc_pkg::ST_PUMP && cmd_take) |=> r_reg.osc_cnt == 5'h00 && !PUMP_TICK;
    endproperty
    a_pump_restart: assert property (p_pump_restart) else $error("Pump period not restarted."); // R12

    // The last oscillator tick of a period of 2n gives one pump pulse.
    property p_pump_edge;
        (CE && OSC_TICK && !cmd_take && r_reg.div != 4'h0 && r_reg.osc_cnt == div_last) |=>
            PUMP_TICK && r_reg.osc_cnt == 5'h00;
    endproperty
    a_pump_edge: assert property (p_pump_edge) else $error("Pump pulse missing at period end."); // R12

    // Every earlier tick of the period only counts.
    property p_pump_gap;
        (CE && OSC_TICK && !cmd_take && r_reg.div != 4'h0 && r_reg.osc_cnt < div_last) |=> !PUMP_TICK;
    endproperty
    a_pump_gap: assert property (p_pump_gap) else $error("Pump pulse inside a period."); // R12

    // With any division above one and CE high, a pump pulse never lasts two cycles.
    property p_pump_pulse;
        (PUMP_TICK && PUMP_DIV_CODE != 4'h0) |=> !PUMP_TICK;
    endproperty
    a_pump_pulse: assert property (p_pump_pulse) else $error("Divided pump pulse too long."); // R12

    // A line that fits the maximum duty is shown as written.
    property p_line_range;
        ({1'b0, r_reg.line} <= max_lines && CE && !(cmd_take && r_reg.state == ldbc_pkg::ST_LINE)) |=>
            PARTIAL_FIRST_LINE == $past(r_reg.line);
    endproperty
    a_line_range: assert property (p_line_range) else $error("In range line not shown."); // R4

    // Any command while pending completes the pair; the host is trusted to send the right one.
    property p_pending_take;
        (r_reg.state != ldbc_pkg::ST_IDLE && cmd_take) |=> !PAIR_PENDING;
    endproperty
    a_pending_take: assert property (p_pending_take) else $error("Pending pair not completed."); // R13

    // Display data writes never touch the decoder, even in the middle of a pair.
    property p_data_write;
        (CE && CMD_WR && COMMAND_DATA_SELECT) |=> $stable(r_reg.state) && $stable(r_reg.line);
    endproperty
    a_data_write: assert property (p_data_write) else $error("Display data taken as command."); // R15

endmodule // ldbc_decoder

// File: common/ldbc_pkg.sv
/*
 * Constants, opcodes and state codes for the two-byte configuration command decoder.
 * Assumes the host port logic delivers one command byte per write strobe on the device clock.
 */
// What this block does
// R1 - Opcode D3h makes the decoder wait for the partial first line data byte as the only next command.
// R2 - The byte that completes the partial line pair stores its low six bits as line 0 to 63.
// R3 - The partial display takes a new first line only once the second byte has written the register.
// R4 - A stored first line beyond the maximum duty set by the two duty pins is used as line zero.
// R5 - Opcode 85h makes the decoder wait for the inversion line count byte as the only next command.
// R6 - The byte that completes the inversion pair stores its low five bits as the line count.
// R7 - Scan lines per polarity inversion equal the stored count plus one, giving 1 to 32.
// R8 - Line-group inversion acts on the display only after its count byte has been written.
// R9 - A partial duty of 1/9 or 1/17 cancels line-group inversion in favour of whole-frame inversion.
// R10 - Opcode 84h leaves line-group inversion and returns to whole-frame inversion.
// R11 - Opcode E6h makes the decoder wait for the pump clock division byte as the only next command.
// R12 - The division byte low four bits pass the oscillator clock for code 0 and divide it by 2n otherwise.
// R13 - The host sends the matching data byte as the very next command after each prefix opcode.
// R14 - After reset the pump clock division code is 0100, dividing by eight.
// R15 - Both bytes of each pair are command writes with the command/data select low.
package ldbc_pkg;
    localparam logic [7:0] OP_LINE_PREFIX = 8'hD3;
    localparam logic [7:0] OP_INV_PREFIX = 8'h85;
    localparam logic [7:0] OP_INV_RELEASE = 8'h84;
    localparam logic [7:0] OP_PUMP_PREFIX = 8'hE6;
    localparam int LINE_W = 6;
    localparam int INV_W = 5;
    localparam int DIV_W = 4;
    localparam logic [5:0] LINE_RESET = 6'h00;
    localparam logic [4:0] INV_RESET = 5'h00;
    localparam logic [3:0] DIV_RESET = 4'h4;
    // Partial duty codes as set by the duty command low bits.
    localparam logic [2:0] DUTY_9 = 3'h0;
    localparam logic [2:0] DUTY_17 = 3'h1;
    // Scan lines of maximum duty for each setting of the two duty pins {high, low}.
    localparam logic [6:0] MAX_LINES_0 = 7'h41;
    localparam logic [6:0] MAX_LINES_1 = 7'h31;
    localparam logic [6:0] MAX_LINES_2 = 7'h21;
    localparam logic [6:0] MAX_LINES_3 = 7'h11;
    // Decoder states, Gray coded along idle, line, inversion, pump.
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LINE = 2'h1,
        ST_INV = 2'h3,
        ST_PUMP = 2'h2
    } ldbc_state_t;
endpackage

// File: tb/ldbc_host.sv
/*
 * Host processor model that writes command bytes into the decoder.
 * Assumes every task is entered 2 ns after a rising edge of clk.
 */
`timescale 1ns/1ns
module ldbc_host (
    input wire logic clk, // Device clock.
    output logic wr, // Write strobe, one cycle per byte.
    output logic sel, // Command/data select, low for commands.
    output logic [7:0] data // Byte on the bus.
);
    // Bus starts quiet so no stray write is taken during reset.
    initial begin
        wr = 1'b0;
        sel = 1'b0;
        data = 8'hFF;
    end
    task automatic send(input logic [7:0] b, input logic s);
        wr = 1'b1;
        sel = s;
        data = b;
        @(posedge clk);
        #2;
    endtask
    // Released bus shows the inverse of the last byte, so a stale value never passes for a write.
    task automatic idle;
        wr = 1'b0;
        data = ~data;
        sel = ~sel;
        @(posedge clk);
        #2;
    endtask
endmodule // ldbc_host

// File: tb/test_ldbc_decoder.sv
/*
 * Self-checking bench for the two-byte command decoder.
 * Assumes the host model drives the command port; the bench drives pins and oscillator ticks.
 */
`timescale 1ns/1ns
module test_ldbc_decoder;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic osc_tick = 1'b0;
    logic mode = 1'b0;
    logic [2:0] pduty = 3'h2;
    logic [1:0] pins = 2'h0;
    logic wr, sel, inv_on, pump_tick, pending;
    logic ce = 1'b1;
    logic [7:0] cbyte;
    logic [5:0] first_line, inv_lines;
    logic [3:0] div_code;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    ////////////////////////////////////////////////////////////////////////
    // Clock at 50 MHz.
    always #10 clk_sys = ~clk_sys;
    ldbc_host HOST (.clk(clk_sys), .wr(wr), .sel(sel), .data(cbyte));
    ldbc_decoder DUT (.CLK_SYS(clk_sys), .RESETN(resetn), .CE(ce), .CMD_WR(wr), .COMMAND_DATA_SELECT(sel),
        .CMD_BYTE(cbyte), .MAX_DUTY_PIN_LOW(pins[0]), .MAX_DUTY_PIN_HIGH(pins[1]), .PARTIAL_MODE(mode),
        .PARTIAL_DUTY(pduty), .OSC_TICK(osc_tick), .PARTIAL_FIRST_LINE(first_line), .LINE_INVERSION_ON(inv_on),
        .INVERSION_LINES(inv_lines), .PUMP_DIV_CODE(div_code), .PUMP_TICK(pump_tick), .PAIR_PENDING(pending));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic pair(input logic [7:0] op, input logic [7:0] val);
        HOST.send(op, 1'b0);
        HOST.send(val, 1'b0);
        HOST.idle();
    endtask
    // A hang is cut short well beyond the few hundred cycles the run needs.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk(8'(first_line), 8'h00);
        chk(8'(inv_lines), 8'h01);
        chk(8'(inv_on), 8'h00);
        chk(8'(pending), 8'h00);
        chk(8'(div_code), 8'h04);
    endtask
    // Clock enable low freezes the decoder, so a prefix written meanwhile is lost.
    task automatic t_freeze;
        ce = 1'b0;
        HOST.send(8'hD3, 1'b0);
        HOST.idle();
        chk(8'(pending), 8'h00);
        ce = 1'b1;
        HOST.idle();
        chk(8'(first_line), 8'h00);
    endtask
    // A second reset mid-run must bring the division code back to its default.
    task automatic t_rereset;
        pair(8'hE6, 8'h02);
        chk(8'(div_code), 8'h02);
        resetn = 1'b0;
        @(posedge clk_sys);
        #2;
        chk(8'(div_code), 8'h04);
        chk(8'(pending), 8'h00);
        resetn = 1'b1;
        HOST.idle();
        chk(8'(div_code), 8'h04);
    endtask
    // Prefix alone must only raise pending and leave inversion off; the count byte's top bits are dropped.
    task automatic t_inv;
        HOST.send(8'h85, 1'b0);
        HOST.idle();
        chk(8'(pending), 8'h01);
        chk(8'(inv_on), 8'h00);
        HOST.send(8'hE0, 1'b0);
        HOST.idle();
        chk(8'(inv_lines), 8'h01);
        chk(8'(inv_on), 8'h01);
        pair(8'h85, 8'hFF);
        chk(8'(inv_lines), 8'h20);
        HOST.send(8'h84, 1'b0);
        HOST.idle();
        chk(8'(inv_on), 8'h00);
    endtask
    // A command byte while waiting is the data byte; a display data write is not.
    task automatic t_line;
        HOST.send(8'hD3, 1'b0);
        HOST.idle();
        chk(8'(pending), 8'h01);
        chk(8'(first_line), 8'h00);
        HOST.send(8'h85, 1'b0);
        HOST.idle();
        chk(8'(first_line), 8'h05);
        chk(8'(pending), 8'h00);
        chk(8'(inv_on), 8'h00);
        HOST.send(8'hD3, 1'b0);
        HOST.send(8'h2A, 1'b1);
        HOST.send(8'hFF, 1'b0);
        HOST.idle();
        chk(8'(first_line), 8'h3F);
        pins = 2'h3;
        HOST.idle();
        HOST.idle();
        chk(8'(first_line), 8'h00);
        pair(8'hD3, 8'h10);
        chk(8'(first_line), 8'h10);
        pins = 2'h0;
    endtask
    // Partial duty codes 0 to 4 in turn; only 1/9 and 1/17 force frame inversion.
    task automatic t_duty;
        pair(8'h85, 8'h03);
        mode = 1'b1;
        for (int d = 0; d < 5; d++) begin
            pduty = 3'(d);
            HOST.idle();
            HOST.idle();
            chk(8'(inv_on), (d > 1) ? 8'h01 : 8'h00);
        end
        mode = 1'b0;
    endtask
    // Count pump pulses over 24 oscillator ticks for codes including both ends.
    task automatic t_pump;
        logic [3:0] codes [5] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'hF};
        int n;
        foreach (codes[k]) begin
            pair(8'hE6, {4'hF, codes[k]});
            chk(8'(div_code), 8'(codes[k]));
            n = 0;
            for (int i = 0; i < 50; i++) begin
                osc_tick = (i < 48) && (i % 2 == 0);
                @(posedge clk_sys);
                #2;
                if (pump_tick === 1'b1) n++;
            end
            chk(8'(n), (codes[k] == 0) ? 8'd24 : 8'(24 / (2 * codes[k])));
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_sys);
        #2;
        resetn = 1'b1;
        t_reset();
        t_freeze();
        t_inv();
        t_line();
        t_duty();
        t_pump();
        t_rereset();
        test_done();
    end
endmodule // test_ldbc_decoder
